// ===== tme_regs.vh
// Constants for the text memory edit engine
// Summary of operation
// - Insert latch; typed chars shift line right
// - Page edit insert shifts through whole memory
// - Line edit stops at two trailing spaces
// - Wrapped terminator triggers automatic line insert
// - Form insert stays inside unprotected field
// - Code mode stores letter code, reverse video
// - Page edit key toggles latch, ESC O clears it
// - Delete char shifts line left, space fills
// - Page edit delete shifts to terminator
// - Form delete spaces field's last location
// - Insert row shifts memory right one location, terminator first
// - Delete row shifts memory up, spaces fill
// - Home moves cursor, clears overwrite latch
// - Tab set marks column on all lines
// - Tab clear removes column stop everywhere
// - Cursor up ignored on first line
// - Cursor down ignored on last line
// - Cursor right wraps, stops at memory end
// - Cursor left wraps, stops at home
// - Transmit terminator sends CR LF
// - Merge switch turns host LF after CR into terminator
// - Suppress switch uppercases keyboard letters
// - Overwrite latch set by carriage return
`ifndef TME_REGS_VH
`define TME_REGS_VH
`define TME_COLS        8'h50
`define TME_ROWS        8'h08
`define TME_MEM_SIZE    10'h280
`define TME_LAST_ADDR   10'h27F
`define TME_SPACE       8'h20
`define TME_NEWLINE     8'h1E
`define TME_DOT         8'h2E
`define TME_CR          8'h0D
`define TME_LF          8'h0A
`define TME_ESC         8'h1B
`define TME_PROT_BIT    8
`define TME_REV_BIT     9
`define TME_CMD_NONE    4'h0
`define TME_CMD_INSC    4'h1
`define TME_CMD_DELC    4'h2
`define TME_CMD_INSR    4'h3
`define TME_CMD_DELR    4'h4
`define TME_CMD_TSET    4'h5
`define TME_CMD_TCLR    4'h6
`define TME_CMD_UP      4'h7
`define TME_CMD_DOWN    4'h8
`define TME_CMD_RIGHT   4'h9
`define TME_CMD_LEFT    4'hA
`define TME_CMD_HOME    4'hB
`define TME_CMD_PEDIT   4'hC
`define TME_CMD_CR      4'hD
`define TME_MODE_CHAR   2'h0
`define TME_MODE_FORM   2'h1
`define TME_MODE_CODE   2'h2
`endif

// ===== tme_case_fold.v
// Keyboard character folding to upper case
`timescale 1ns/1ps
`default_nettype none
module tme_case_fold
(
  // Clock and reset
  input  wire       core_clk,
  input  wire       reset_n,
  // Character path
  input  wire       fold_en,
  input  wire [7:0] char_in,
  output reg  [7:0] char_q
);
  wire lower = (char_in >= 8'h61) && (char_in <= 8'h7A);
  // Registered fold of lower case letters
  always @(posedge core_clk)
  begin
    if (!reset_n)
      char_q <= 8'h00;
    else if (fold_en && lower)
      char_q <= char_in & 8'hDF;
    else
      char_q <= char_in;
  end
endmodule // tme_case_fold
`default_nettype wire

// ===== tme_edit_engine.v
// Edit and cursor command engine over the page memory
`timescale 1ns/1ps
`default_nettype none
`include "tme_regs.vh"
module tme_edit_engine
(
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  // Command and character input
  input  wire        cmd_valid,
  input  wire [3:0]  cmd_code,
  input  wire        kbd_valid,
  input  wire [7:0]  kbd_char,
  input  wire        host_valid,
  input  wire [7:0]  host_char,
  // Configuration
  input  wire [1:0]  mode_sel,
  input  wire        line_edit_sel,
  input  wire        crlf_merge_switch,
  input  wire        lowercase_suppress_switch,
  input  wire        xmit_start,
  // Memory read port
  input  wire [9:0]  rd_addr,
  output reg  [9:0]  rd_data_q,
  // Status
  output reg  [9:0]  cursor_q,
  output reg         busy_q,
  output reg         insert_latch_q,
  output reg         page_edit_latch_q,
  output reg         space_bar_overwrite_latch,
  output reg  [79:0] tab_stops_q,
  // Transmit stream
  output reg         tx_valid_q,
  output reg  [7:0]  tx_char_q
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_SHR   = 3'd1;
  localparam ST_SHL   = 3'd2;
  localparam ST_XMIT  = 3'd3;
  localparam ST_XLF   = 3'd4;
  // Character memory: bit 8 protect, bit 9 reverse video
  reg [9:0] mem_q [0:639];
  reg [2:0] st_q;
  reg [9:0] ptr_q;
  reg [9:0] end_q;
  reg [9:0] carry_q;
  reg       esc_q;
  reg       host_esc_q;
  reg       cr_pend_q;
  wire [7:0] kchar;
  integer i, j, k, n;
  tme_case_fold u_fold
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .fold_en  (lowercase_suppress_switch),
    .char_in  (kbd_char),
    .char_q   (kchar)
  );
  reg kv_q;
  // Align keyboard strobe with folded character
  always @(posedge core_clk)
  begin
    if (!reset_n)
      kv_q <= 1'b0;
    else
      kv_q <= kbd_valid;
  end
  // Column of an address
  function [6:0] col_of;
    input [9:0] a;
    reg   [9:0] r;
    begin
      r = a % 10'd80;
      col_of = r[6:0];
    end
  endfunction
  // Last address of the line holding an address
  function [9:0] line_end;
    input [9:0] a;
    line_end = a - col_of(a) + 10'd79;
  endfunction
  wire [9:0] cur_le = line_end(cursor_q);
  wire is_form = (mode_sel == `TME_MODE_FORM);
  wire is_code = (mode_sel == `TME_MODE_CODE);
  wire cur_prot = mem_q[cursor_q][`TME_PROT_BIT];
  // Field end: last unprotected address from cursor onward
  reg [9:0] fld_end;
  reg [9:0] nxt_fld;
  reg       fnd;
  always @*
  begin
    fld_end = cursor_q;
    nxt_fld = cursor_q;
    fnd = 1'b0;
    for (i = 0; i < 640; i = i + 1)
    begin
      if (i > cursor_q && !fnd)
      begin
        if (mem_q[i][`TME_PROT_BIT])
          fnd = 1'b1;
        else
          fld_end = i[9:0];
      end
    end
    fnd = 1'b0;
    for (i = 0; i < 640; i = i + 1)
    begin
      if (i > fld_end + 10'd1 && !fnd && !mem_q[i][`TME_PROT_BIT])
      begin
        nxt_fld = i[9:0];
        fnd = 1'b1;
      end
    end
  end
  // First unprotected address
  reg [9:0] first_unp;
  reg       fu;
  always @*
  begin
    first_unp = 10'd0;
    fu = 1'b0;
    for (j = 0; j < 640; j = j + 1)
    begin
      if (!fu && !mem_q[j][`TME_PROT_BIT])
      begin
        first_unp = j[9:0];
        fu = 1'b1;
      end
    end
  end
  // Line-limited stop: first line ending in two spaces
  reg [9:0] le_stop;
  reg       ls;
  always @*
  begin
    le_stop = `TME_LAST_ADDR;
    ls = 1'b0;
    for (k = 79; k < 640; k = k + 80)
    begin
      if (!ls && k >= cur_le && mem_q[k][7:0] == `TME_SPACE
          && mem_q[k-1][7:0] == `TME_SPACE)
      begin
        le_stop = k[9:0];
        ls = 1'b1;
      end
    end
  end
  // Terminator search for page edit delete
  reg [9:0] nl_pos;
  reg       nf;
  always @*
  begin
    nl_pos = `TME_LAST_ADDR;
    nf = 1'b0;
    for (n = 0; n < 640; n = n + 1)
    begin
      if (!nf && n > cursor_q && mem_q[n][7:0] == `TME_NEWLINE)
      begin
        nl_pos = n[9:0];
        nf = 1'b1;
      end
    end
  end
  // Character to store and the code mode letter code
  reg [7:0] insert_character_cmd;
  reg       ins_ok;
  reg [7:0] code_char;
  always @*
  begin
    ins_ok = kv_q || host_valid;
    insert_character_cmd = kv_q ? kchar : host_char;
    case (cmd_code)
      `TME_CMD_INSC:  code_char = 8'h51;
      `TME_CMD_DELC:  code_char = 8'h50;
      `TME_CMD_INSR:  code_char = 8'h4C;
      `TME_CMD_DELR:  code_char = 8'h4D;
      `TME_CMD_TSET:  code_char = 8'h31;
      `TME_CMD_TCLR:  code_char = 8'h32;
      `TME_CMD_UP:    code_char = 8'h41;
      `TME_CMD_DOWN:  code_char = 8'h42;
      `TME_CMD_RIGHT: code_char = 8'h43;
      `TME_CMD_LEFT:  code_char = 8'h44;
      `TME_CMD_HOME:  code_char = 8'h48;
      default:        code_char = 8'h00;
    endcase
  end
  wire esc_o = (kv_q && esc_q && kchar == 8'h4F) ||
               (host_valid && host_esc_q && host_char == 8'h4F);
  wire merged = host_valid && cr_pend_q && host_char == `TME_LF && crlf_merge_switch;
  // Main sequencer
  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      st_q <= ST_IDLE;
      cursor_q <= 10'd0;
      busy_q <= 1'b0;
      insert_latch_q <= 1'b0;
      page_edit_latch_q <= 1'b0;
      space_bar_overwrite_latch <= 1'b0;
      tab_stops_q <= 80'h0;
      tx_valid_q <= 1'b0;
      tx_char_q <= 8'h00;
      ptr_q <= 10'd0;
      end_q <= 10'd0;
      carry_q <= 10'd0;
      esc_q <= 1'b0;
      host_esc_q <= 1'b0;
      cr_pend_q <= 1'b0;
      rd_data_q <= 10'd0;
    end
    else
    begin
      rd_data_q <= mem_q[rd_addr];
      tx_valid_q <= 1'b0;
      if (kv_q)
        esc_q <= (kchar == `TME_ESC);
      if (host_valid)
      begin
        host_esc_q <= (host_char == `TME_ESC);
        cr_pend_q <= (host_char == `TME_CR);
      end
      if (esc_o)
        page_edit_latch_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          busy_q <= 1'b0;
          if (xmit_start)
          begin
            st_q <= ST_XMIT;
            busy_q <= 1'b1;
          end
          else if (cmd_valid && is_code && code_char != 8'h00)
          begin
            mem_q[cursor_q] <= {1'b1, 1'b0, code_char};
            if (cmd_code != `TME_CMD_HOME && cursor_q != `TME_LAST_ADDR)
              cursor_q <= cursor_q + 10'd1;
          end
          else if (cmd_valid)
          begin
            case (cmd_code)
              `TME_CMD_INSC: if (!is_form) insert_latch_q <= ~insert_latch_q;
              `TME_CMD_PEDIT: if (!is_form) page_edit_latch_q <= ~page_edit_latch_q;
              `TME_CMD_CR: space_bar_overwrite_latch <= 1'b1;
              `TME_CMD_HOME:
              begin
                cursor_q <= is_form ? first_unp : 10'd0;
                space_bar_overwrite_latch <= 1'b0;
              end
              `TME_CMD_TSET: if (!is_form) tab_stops_q[col_of(cursor_q)] <= 1'b1;
              `TME_CMD_TCLR: if (!is_form) tab_stops_q[col_of(cursor_q)] <= 1'b0;
              `TME_CMD_UP: if (cursor_q >= 10'd80) cursor_q <= cursor_q - 10'd80;
              `TME_CMD_DOWN: if (cursor_q < 10'd560) cursor_q <= cursor_q + 10'd80;
              `TME_CMD_RIGHT: if (cursor_q != `TME_LAST_ADDR) cursor_q <= cursor_q + 10'd1;
              `TME_CMD_LEFT: if (cursor_q != 10'd0) cursor_q <= cursor_q - 10'd1;
              `TME_CMD_DELC:
              begin
                st_q <= ST_SHL;
                busy_q <= 1'b1;
                ptr_q <= cursor_q;
                carry_q <= {2'b00, `TME_SPACE};
                if (is_form)
                  end_q <= fld_end;
                else if (page_edit_latch_q)
                  end_q <= nl_pos;
                else
                  end_q <= cur_le;
              end
              `TME_CMD_INSR:
              if (!is_form)
              begin
                st_q <= ST_SHR;
                busy_q <= 1'b1;
                ptr_q <= cursor_q - col_of(cursor_q);
                end_q <= `TME_LAST_ADDR;
                carry_q <= {2'b00, `TME_NEWLINE};
              end
              `TME_CMD_DELR:
              if (!is_form)
              begin
                st_q <= ST_SHL;
                busy_q <= 1'b1;
                ptr_q <= cursor_q - col_of(cursor_q);
                end_q <= `TME_LAST_ADDR;
                carry_q <= 10'd80;
              end
              default: ;
            endcase
          end
          else if (ins_ok && !is_code && !(is_form && cur_prot))
          begin
            if (merged)
              mem_q[cursor_q] <= {2'b00, `TME_NEWLINE};
            else if (insert_latch_q || is_form)
            begin
              st_q <= ST_SHR;
              busy_q <= 1'b1;
              ptr_q <= cursor_q;
              carry_q <= {2'b00, insert_character_cmd};
              if (is_form)
                end_q <= fld_end;
              else if (page_edit_latch_q)
                end_q <= line_edit_sel ? le_stop : `TME_LAST_ADDR;
              else
                end_q <= cur_le;
              if (is_form && cursor_q == fld_end)
                cursor_q <= nxt_fld;
              else if (cursor_q != `TME_LAST_ADDR)
                cursor_q <= cursor_q + 10'd1;
            end
            else
            begin
              mem_q[cursor_q] <= {2'b00, insert_character_cmd};
              if (cursor_q != `TME_LAST_ADDR)
                cursor_q <= cursor_q + 10'd1;
            end
          end
        end
        ST_SHR:
        begin
          // Ripple right; overflow past end_q is dropped
          mem_q[ptr_q] <= carry_q;
          carry_q <= mem_q[ptr_q];
          if (ptr_q == end_q)
            st_q <= ST_IDLE;
          else if (page_edit_latch_q && col_of(ptr_q) == 7'd79 &&
                   mem_q[ptr_q][7:0] == `TME_NEWLINE)
            end_q <= `TME_LAST_ADDR;
          ptr_q <= ptr_q + 10'd1;
        end
        ST_SHL:
        begin
          // carry_q holds the row shift distance when equal to 80, else the fill character
          if (carry_q == 10'd80)
          begin
            mem_q[ptr_q] <= (ptr_q < 10'd560) ? mem_q[ptr_q + 10'd80]
                                               : {2'b00, `TME_SPACE};
            if (ptr_q == end_q)
              st_q <= ST_IDLE;
            ptr_q <= ptr_q + 10'd1;
          end
          else
          begin
            mem_q[ptr_q] <= (ptr_q == end_q) ? carry_q : mem_q[ptr_q + 10'd1];
            if (ptr_q == end_q)
            begin
              st_q <= ST_IDLE;
              if (page_edit_latch_q && col_of(ptr_q) == 7'd0 && ptr_q != 10'd0 &&
                  mem_q[ptr_q][7:0] == `TME_NEWLINE)
              begin
                st_q <= ST_SHL;
                ptr_q <= ptr_q - 10'd80;
                end_q <= `TME_LAST_ADDR;
                carry_q <= 10'd80;
              end
            end
            else
              ptr_q <= ptr_q + 10'd1;
          end
        end
        ST_XMIT:
        begin
          tx_valid_q <= 1'b1;
          if (mem_q[cursor_q][7:0] == `TME_NEWLINE)
          begin
            tx_char_q <= `TME_CR;
            st_q <= ST_XLF;
          end
          else
            tx_char_q <= mem_q[cursor_q][7:0];
          if (cursor_q == `TME_LAST_ADDR)
            st_q <= (mem_q[cursor_q][7:0] == `TME_NEWLINE) ? ST_XLF : ST_IDLE;
          else if (mem_q[cursor_q][7:0] == `TME_NEWLINE)
            cursor_q <= is_form ? nxt_fld : line_end(cursor_q) + 10'd1;
          else
            cursor_q <= cursor_q + 10'd1;
        end
        ST_XLF:
        begin
          tx_valid_q <= 1'b1;
          tx_char_q <= `TME_LF;
          st_q <= (cursor_q == `TME_LAST_ADDR) ? ST_IDLE : ST_XMIT;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // tme_edit_engine
`default_nettype wire

// ===== tme_edit_checker.sv
// Port assertions for the edit engine
`timescale 1ns/1ps
`default_nettype none
`include "tme_regs.vh"
module tme_edit_checker
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // Command side
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_code,
  input wire logic [1:0]  mode_sel,
  // Status side
  input wire logic [9:0]  cursor_q,
  input wire logic        busy_q,
  input wire logic        insert_latch_q,
  input wire logic        space_bar_overwrite_latch,
  input wire logic [79:0] tab_stops_q
);
  // Accepted command in an editing mode, and the cursor column
  wire logic       go  = cmd_valid && !busy_q && mode_sel != `TME_MODE_CODE;
  wire logic       chr = go && mode_sel == `TME_MODE_CHAR;
  wire logic       frm = go && mode_sel == `TME_MODE_FORM;
  wire logic [9:0] col = cursor_q % 10'd80;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Latch flips on each accepted command
  property p_flip(logic c, logic q);
    c |=> q != $past(q);
  endproperty
  a_insert_toggle: assert property (p_flip(chr && cmd_code == `TME_CMD_INSC, insert_latch_q))
    else $error("insert latch did not toggle");
  a_home_cursor: assert property (chr && cmd_code == `TME_CMD_HOME |=>
    cursor_q == 10'h000 && !space_bar_overwrite_latch) else $error("home failed");
  a_cr_overwrite: assert property (go && cmd_code == `TME_CMD_CR |=> space_bar_overwrite_latch)
    else $error("return did not set overwrite");
  a_up_step: assert property (go && cmd_code == `TME_CMD_UP |=> cursor_q ==
    ($past(cursor_q) < 10'd80 ? $past(cursor_q) : $past(cursor_q) - 10'd80))
    else $error("cursor up wrong");
  a_down_step: assert property (go && cmd_code == `TME_CMD_DOWN |=> cursor_q ==
    ($past(cursor_q) > 10'd559 ? $past(cursor_q) : $past(cursor_q) + 10'd80))
    else $error("cursor down wrong");
  a_right_step: assert property (go && cmd_code == `TME_CMD_RIGHT && cursor_q != 10'h27F
    |=> cursor_q == $past(cursor_q) + 10'd1) else $error("cursor right wrong");
  a_left_stop: assert property (go && cmd_code == `TME_CMD_LEFT && cursor_q == 10'h000
    |=> $stable(cursor_q)) else $error("cursor left moved at home");
  a_tab_set: assert property (chr && cmd_code == `TME_CMD_TSET |=> tab_stops_q[$past(col)])
    else $error("tab not set");
  a_tab_clear: assert property (chr && cmd_code == `TME_CMD_TCLR |=> !tab_stops_q[$past(col)])
    else $error("tab not cleared");
  a_form_tabs: assert property (frm && cmd_code inside {`TME_CMD_TSET, `TME_CMD_TCLR}
    |=> $stable(tab_stops_q) [*2]) else $error("form mode changed tabs");
  a_form_rows: assert property (frm && cmd_code inside {`TME_CMD_INSR, `TME_CMD_DELR}
    |=> !busy_q && $stable(cursor_q)) else $error("form mode row edit acted");
  // Main scenarios reached
  c_insert: cover property (chr && cmd_code == `TME_CMD_INSC);
  c_shift: cover property ($rose(busy_q));
  c_wrap: cover property (go && cmd_code == `TME_CMD_RIGHT && cursor_q == 10'h04F);
endmodule // tme_edit_checker
bind tme_edit_engine tme_edit_checker u_tme_edit_checker (.core_clk, .reset_n, .cmd_valid,
  .cmd_code, .mode_sel, .cursor_q, .busy_q, .insert_latch_q, .space_bar_overwrite_latch,
  .tab_stops_q);
`default_nettype wire

// ===== tme_key_host.sv
// Keyboard and host line model for the edit engine
`timescale 1ns/1ps
`default_nettype none
`include "tme_regs.vh"
module tme_key_host
(
  // Clock
  input  wire logic  core_clk,
  // Keyboard and host strobes
  output logic       kbd_valid,
  output logic [7:0] kbd_char,
  output logic       host_valid,
  output logic [7:0] host_char
);
  // Lines idle at time zero
  initial
  begin
    kbd_valid = 1'b0;
    host_valid = 1'b0;
    kbd_char = 8'h00;
    host_char = 8'h00;
  end
  // One-cycle strobe, then the data line shows junk
  task automatic put(input logic h, input logic [7:0] c);
    @(negedge core_clk);
    if (h)
    begin
      host_valid = 1'b1;
      host_char = c;
    end
    else
    begin
      kbd_valid = 1'b1;
      kbd_char = c;
    end
    @(negedge core_clk);
    host_valid = 1'b0;
    kbd_valid = 1'b0;
    host_char = ~host_char;
    kbd_char = ~kbd_char;
  endtask
  // Escape then O ends page editing
  task automatic esc_o(input logic h);
    put(h, `TME_ESC);
    repeat (3) @(negedge core_clk);
    put(h, 8'h4F);
  endtask
endmodule // tme_key_host
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the edit engine
`timescale 1ns/1ps
`default_nettype none
`include "tme_regs.vh"
module tb;
  logic             core_clk;
  logic             reset_n;
  logic             cmd_valid;
  logic [3:0]       cmd_code;
  logic [1:0]       mode_sel;
  logic             lowercase_suppress_switch;
  logic             line_edit_sel;
  logic             crlf_merge_switch;
  logic             xmit_start;
  logic [9:0]       rd_addr;
  logic [79:0]      code_txt;
  logic [3:0]       ops [10];
  wire logic        kbd_valid;
  wire logic        host_valid;
  wire logic [7:0]  kbd_char;
  wire logic [7:0]  host_char;
  wire logic [9:0]  rd_data_q;
  wire logic [9:0]  cursor_q;
  wire logic        busy_q;
  wire logic        insert_latch_q;
  wire logic        page_edit_latch_q;
  wire logic        space_bar_overwrite_latch;
  wire logic [79:0] tab_stops_q;
  wire logic        tx_valid_q;
  wire logic [7:0]  tx_char_q;
  int               n_errors;
  int               checks_done;
  int               i;
  // Engine and its keyboard and host partner
  tme_edit_engine u_tme_edit_engine (.core_clk, .reset_n, .cmd_valid, .cmd_code, .kbd_valid,
    .kbd_char, .host_valid, .host_char, .mode_sel, .line_edit_sel,
    .crlf_merge_switch, .lowercase_suppress_switch, .xmit_start, .rd_addr,
    .rd_data_q, .cursor_q, .busy_q, .insert_latch_q, .page_edit_latch_q,
    .space_bar_overwrite_latch, .tab_stops_q, .tx_valid_q, .tx_char_q);
  tme_key_host u_tme_key_host (.core_clk, .kbd_valid, .kbd_char, .host_valid, .host_char);
  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic check(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Wait for the engine to go idle, bounded
  task automatic idle();
    int k;
    k = 0;
    @(negedge core_clk);
    while (busy_q !== 1'b0 && k < 3000)
    begin
      @(negedge core_clk);
      k++;
    end
    if (k == 3000)
    begin
      n_errors++;
      report_and_stop();
    end
  endtask
  task automatic cmd(input logic [3:0] c);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    idle();
  endtask
  task automatic cmdc(input logic [3:0] c, input logic [9:0] e);
    cmd(c);
    check("cursor", 80'(cursor_q), 80'(e));
  endtask
  task automatic key(input logic h, input logic [7:0] c);
    u_tme_key_host.put(h, c);
    repeat (2) @(negedge core_clk);
    idle();
  endtask
  task automatic rd(input logic [9:0] a, input logic [9:0] e);
    @(negedge core_clk);
    rd_addr = a;
    @(negedge core_clk);
    check("memory", 80'(rd_data_q), 80'(e));
  endtask
  // Main sequence
  initial
  begin
    n_errors = 0;
    checks_done = 0;
    cmd_valid = 1'b0;
    cmd_code = `TME_CMD_NONE;
    mode_sel = `TME_MODE_CHAR;
    lowercase_suppress_switch = 1'b0;
    line_edit_sel = 1'b0;
    crlf_merge_switch = 1'b0;
    xmit_start = 1'b0;
    rd_addr = 10'h000;
    code_txt = "QPLM12ABCD";
    ops = '{`TME_CMD_INSC, `TME_CMD_DELC, `TME_CMD_INSR, `TME_CMD_DELR, `TME_CMD_TSET,
      `TME_CMD_TCLR, `TME_CMD_UP, `TME_CMD_DOWN, `TME_CMD_RIGHT, `TME_CMD_LEFT};
    reset_n = 1'b0;
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    check("tabs", tab_stops_q, 80'h0);
    for (i = 0; i < 8; i++)
      cmd(`TME_CMD_DELR);
    rd(10'h27F, 10'h020);
    rd(10'h000, 10'h020);
    $display("test row delete done");
    cmdc(`TME_CMD_LEFT, 10'h000);
    cmdc(`TME_CMD_UP, 10'h000);
    cmdc(`TME_CMD_DOWN, 10'h050);
    cmdc(`TME_CMD_LEFT, 10'h04F);
    cmdc(`TME_CMD_RIGHT, 10'h050);
    cmdc(`TME_CMD_UP, 10'h000);
    for (i = 0; i < 7; i++)
      cmd(`TME_CMD_DOWN);
    cmdc(`TME_CMD_DOWN, 10'h230);
    for (i = 0; i < 79; i++)
      cmd(`TME_CMD_RIGHT);
    cmdc(`TME_CMD_RIGHT, 10'h27F);
    cmd(`TME_CMD_CR);
    check("overwrite", 80'(space_bar_overwrite_latch), 80'h1);
    cmdc(`TME_CMD_HOME, 10'h000);
    check("overwrite", 80'(space_bar_overwrite_latch), 80'h0);
    $display("test cursor done");
    for (i = 0; i < 5; i++)
      cmd(`TME_CMD_RIGHT);
    cmd(`TME_CMD_TSET);
    check("tabs", tab_stops_q, 80'h20);
    mode_sel = `TME_MODE_FORM;
    cmd(`TME_CMD_TCLR);
    check("tabs", tab_stops_q, 80'h20);
    cmdc(`TME_CMD_INSR, 10'h005);
    mode_sel = `TME_MODE_CHAR;
    cmd(`TME_CMD_TCLR);
    check("tabs", tab_stops_q, 80'h0);
    $display("test tabs done");
    cmd(`TME_CMD_HOME);
    lowercase_suppress_switch = 1'b1;
    key(1'b0, 8'h61);
    key(1'b1, 8'h62);
    lowercase_suppress_switch = 1'b0;
    key(1'b0, 8'h43);
    rd(10'h000, 10'h041);
    rd(10'h001, 10'h062);
    cmd(`TME_CMD_HOME);
    cmdc(`TME_CMD_DELC, 10'h000);
    rd(10'h000, 10'h062);
    rd(10'h04F, 10'h020);
    cmd(`TME_CMD_INSC);
    check("insert", 80'(insert_latch_q), 80'h1);
    key(1'b0, 8'h5A);
    check("cursor", 80'(cursor_q), 80'h1);
    rd(10'h001, 10'h062);
    cmd(`TME_CMD_INSC);
    cmd(`TME_CMD_HOME);
    cmd(`TME_CMD_INSR);
    rd(10'h000, 10'h01E);
    rd(10'h001, 10'h05A);
    $display("test editing done");
    cmd(`TME_CMD_PEDIT);
    check("page edit", 80'(page_edit_latch_q), 80'h1);
    u_tme_key_host.esc_o(1'b1);
    idle();
    check("page edit", 80'(page_edit_latch_q), 80'h0);
    cmd(`TME_CMD_PEDIT);
    u_tme_key_host.esc_o(1'b0);
    repeat (2) @(negedge core_clk);
    idle();
    check("page edit", 80'(page_edit_latch_q), 80'h0);
    $display("test page edit done");
    cmd(`TME_CMD_HOME);
    mode_sel = `TME_MODE_CODE;
    for (i = 0; i < 10; i++)
    begin
      cmd(ops[i]);
      rd(10'(i), {2'b10, code_txt[79 - 8 * i -: 8]});
    end
    cmdc(`TME_CMD_HOME, 10'h00A);
    rd(10'h00A, 10'h248);
    $display("test code display done");
    mode_sel = `TME_MODE_CHAR;
    crlf_merge_switch = 1'b1;
    cmd(`TME_CMD_HOME);
    key(1'b1, `TME_CR);
    key(1'b1, `TME_LF);
    crlf_merge_switch = 1'b0;
    rd(10'h001, 10'h01E);
    @(negedge core_clk);
    xmit_start = 1'b1;
    @(negedge core_clk);
    xmit_start = 1'b0;
    @(negedge core_clk);
    check("tx", 80'({tx_valid_q, tx_char_q}), 80'h10D);
    @(negedge core_clk);
    check("tx", 80'({tx_valid_q, tx_char_q}), 80'h10A);
    cmdc(`TME_CMD_HOME, 10'h27F);
    $display("test transmit done");
    cmd(`TME_CMD_HOME);
    for (i = 0; i < 8; i++)
      cmd(`TME_CMD_DELR);
    cmd(`TME_CMD_DOWN);
    cmd(`TME_CMD_DOWN);
    key(1'b0, 8'h56);
    cmd(`TME_CMD_HOME);
    cmd(`TME_CMD_INSC);
    cmd(`TME_CMD_PEDIT);
    line_edit_sel = 1'b1;
    key(1'b0, 8'h58);
    rd(10'h0A0, 10'h056);
    rd(10'h000, 10'h058);
    line_edit_sel = 1'b0;
    key(1'b0, 8'h59);
    rd(10'h0A1, 10'h056);
    $display("test page insert done");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
